// [bench/tcp_ext_source.sv]
// Behavioural source that drives the external count pin.
`timescale 1ns/1ns
`default_nettype none
module tcp_ext_source (
    // Pacing clock.
    input wire logic clk,
    // Count pin.
    output logic pin
);
    initial pin = 1'b0;

    // Each level is held for at least two clocks; the 3 ns offset keeps the edge
    // away from the sampling edge, as an unrelated source would.
    task automatic edges(input int n, input int hold);
        repeat (n) begin
            repeat (hold) @(posedge clk);
            #3 pin = ~pin;
        end
        @(posedge clk);
    endtask
endmodule // tcp_ext_source
`default_nettype wire

// [bench/test_timer_counter_with_shared_prescaler.sv]
// Self-checking testbench for the timer/counter with shared prescaler.
`timescale 1ns/1ns
`default_nettype none
`include "tcp_regs.svh"
module test_timer_counter_with_shared_prescaler;
    import tcp_pkg::*;
    logic clk, sys_rst, regWr, regRd, extPin, wdOsc, wdEnable, wdTimeout;
    tcp_byte_t regAddr, regWrData, regRdData, v, r1, d;
    tcp_byte_t rdQ[$];
    logic [5:0] mOpt;
    logic ms1, ms2, ms3;
    int failures = 0;
    int checked = 0;
    int mCnt, mHold, base;
    int toCount = 0;

    tcp_timer DUT (.clk(clk), .sys_rst(sys_rst), .regAddr(regAddr), .regWrData(regWrData),
        .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .externalCountInput(extPin),
        .watchdogOscillator(wdOsc), .watchdogEnableConfig(wdEnable),
        .watchdogTimeout(wdTimeout));
    tcp_ext_source src (.clk(clk), .pin(extPin));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Cycle-exact reference of the count register with the prescaler off (option bit 3 set), fed from the same port signals.
    always @(posedge clk) begin
        if (sys_rst) begin
            mCnt = 0;
            mHold = 0;
            mOpt = `TCP_OPT_RESET;
        end else begin
            if (regRd)
                rdQ.push_back(regAddr == `TCP_ADDR_COUNT ? tcp_byte_t'(mCnt) : 8'h00);
            if (regWr && regAddr == `TCP_ADDR_COUNT) begin
                mCnt = regWrData;
                mHold = 2;
            end else if (mHold > 0)
                mHold--;
            else if (mOpt[3] && (!mOpt[5] || (ms2 != ms3 && ms2 == !mOpt[4])))
                mCnt = (mCnt + 1) % 256;
            if (regWr && regAddr == `TCP_ADDR_OPTION)
                mOpt = regWrData[5:0];
        end
        ms1 <= extPin;
        ms2 <= ms1;
        ms3 <= ms2;
        if (wdTimeout === 1'b1)
            toCount++;
    end

    task check(input string what, input logic [7:0] want, input logic [7:0] got);
        checked++;
        if (got !== want) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, want, got);
        end
    endtask

    task op(input logic w, input logic r, input tcp_byte_t a, input tcp_byte_t dat);
        regWr <= w;
        regRd <= r;
        regAddr <= a;
        regWrData <= dat;
        @(posedge clk);
    endtask

    task idle(input int n);
        regWr <= 1'b0;
        regRd <= 1'b0;
        repeat (n) @(posedge clk);
    endtask

    // Read data stand only in the cycle after the strobe, so they are taken mid-cycle.
    task rd(input tcp_byte_t a, output tcp_byte_t val, output tcp_byte_t want);
        op(1'b0, 1'b1, a, 8'h00);
        regRd <= 1'b0;
        #2;
        val = regRdData;
        want = rdQ.pop_front();
        @(posedge clk);
    endtask

    task rdCheck(input tcp_byte_t a);
        tcp_byte_t val, want;
        rd(a, val, want);
        check("readData", want, val);
    endtask

    task wdTicks(input int n);
        repeat (2 * n) begin
            repeat (3) @(posedge clk);
            wdOsc <= ~wdOsc;
        end
    endtask

    task complete_run;
        $display("checks %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        complete_run;
    end

    initial begin
        {regWr, regRd, wdOsc, wdEnable, sys_rst} = 5'h01;
        regAddr = 8'h00;
        regWrData = 8'h00;
        void'($urandom(26));
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        rdCheck(`TCP_ADDR_COUNT);
        rd(`TCP_ADDR_OPTION, v, d);
        check("optionReset", 8'h3F, v);
        for (int a = 5; a < 16; a++)
            rdCheck(tcp_byte_t'(a));
        wr_timer: for (int k = 0; k < 6; k++) begin
            op(1'b1, 1'b0, `TCP_ADDR_OPTION, 8'h08);
            d = (k == 5) ? 8'hFE : tcp_byte_t'($urandom);
            op(1'b1, 1'b0, `TCP_ADDR_COUNT, d);
            if (k > 0)
                idle(k);
            rdCheck(`TCP_ADDR_COUNT);
        end
        for (int m = 0; m < 4; m++) begin
            op(1'b1, 1'b0, `TCP_ADDR_OPTION, m[0] ? 8'h38 : 8'h28);
            op(1'b1, 1'b0, `TCP_ADDR_COUNT, tcp_byte_t'($urandom));
            idle(4);
            src.edges(1 + $urandom % 9, m[1] ? 5 : 2);
            idle(6);
            rdCheck(`TCP_ADDR_COUNT);
        end
        // Two scaled steps must land in a window of twice the ratio that starts when the option write clears the prescaler.
        for (int r = 0; r < 8; r++) begin
            op(1'b1, 1'b0, `TCP_ADDR_OPTION, tcp_byte_t'(r));
            rd(`TCP_ADDR_COUNT, r1, d);
            idle((4 << r) - 2);
            rd(`TCP_ADDR_COUNT, v, d);
            check("scaledSteps", r1 + 8'h02, v);
        end
        wdEnable <= 1'b1;
        idle(4);
        op(1'b1, 1'b0, `TCP_ADDR_WDCLR, 8'h00);
        idle(4);
        base = toCount;
        wdTicks(255);
        check("timeoutEarly", 8'h00, tcp_byte_t'(toCount - base));
        wdTicks(1);
        idle(6);
        check("timeoutDue", 8'h01, tcp_byte_t'(toCount - base));
        wdEnable <= 1'b0;
        idle(4);
        op(1'b1, 1'b0, `TCP_ADDR_WDCLR, 8'h00);
        idle(4);
        base = toCount;
        wdTicks(300);
        check("timeoutOff", 8'h00, tcp_byte_t'(toCount - base));
        complete_run;
    end
endmodule // test_timer_counter_with_shared_prescaler
`default_nettype wire

// [include/tcp_pkg.sv]
// Types shared by the timer/counter modules.
package tcp_pkg;
    typedef logic [7:0] tcp_byte_t;
    typedef logic [2:0] tcp_rate_t;
    typedef logic [5:0] tcp_option_t;
    typedef enum logic [1:0] {TCP_RUN, TCP_HOLD_A, TCP_HOLD_B} tcp_hold_t;
endpackage

// [include/tcp_presc_if.sv]
// Connection between the timer/counter and its shared prescaler.
`timescale 1ns/1ns
`default_nettype none
interface tcp_presc_if;
    logic srcTick;
    tcp_pkg::tcp_rate_t rate;
    logic clear;
    logic divTick;
    modport core (input srcTick, input rate, input clear, output divTick);
    modport user (output srcTick, output rate, output clear, input divTick);
endinterface
`default_nettype wire

// [include/tcp_regs.svh]
// Register offsets, field positions, reset values and counts of the timer/counter block.
// What this block does
// - Eight-bit count register, readable and writable.
// - Source select clear selects instruction-cycle timer mode.
// - Timer mode without prescaler steps every cycle.
// - Count write holds off stepping two cycles.
// - Source select set counts external input edges.
// - Counter mode uses one edge type only.
// - Edge select clear rising, set falling.
// - Prescaler serves timer or watchdog, never both.
// - Assign bit clear gives prescaler to timer.
// - Prescaler count has no software access path.
// - Prescaler ratios from two up to 256.
// - Watchdog disabled only by configuration enable.
// - Watchdog steps from its own oscillator.
`ifndef TCP_REGS_SVH
`define TCP_REGS_SVH

`define TCP_ADDR_COUNT 8'h01
`define TCP_ADDR_OPTION 8'h02
`define TCP_ADDR_WDCLR 8'h03
`define TCP_ADDR_STATUS 8'h04

`define TCP_OPT_CS 5
`define TCP_OPT_SE 4
`define TCP_OPT_PSA 3
`define TCP_OPT_RATE_HI 2
`define TCP_OPT_RATE_LO 0
`define TCP_OPT_RESET 6'h3F

`define TCP_BYTE_ZERO 8'h00
`define TCP_BYTE_ONE 8'h01
`define TCP_BYTE_ONES 8'hFF
`define TCP_COUNT_RESET 8'h00
`define TCP_WD_RESET 8'h00

`endif

// [logic/tcp_prescaler.sv]
// Shared power-of-two prescaler, invisible to software.
`timescale 1ns/1ns
`default_nettype none
`include "tcp_regs.svh"
module tcp_prescaler (
    // Clock and reset.
    input wire logic clk,
    input wire logic sys_rst,
    // Prescaler connection.
    tcp_presc_if.core presc
);
    import tcp_pkg::*;

    tcp_byte_t count;
    tcp_byte_t mask;

    // A bit takes part in the division when its index is within the rate.
    genvar i;
    generate
        for (i = 0; i < 8; i++) begin : g_mask
            assign mask[i] = (i <= int'(presc.rate));
        end
    endgenerate

    // One output tick when the selected low bits are about to wrap.
    assign presc.divTick = presc.srcTick && ((count | ~mask) == `TCP_BYTE_ONES);

    always_ff @(posedge clk) begin
        if (sys_rst || presc.clear) begin
            count <= `TCP_BYTE_ZERO;
        end else if (presc.srcTick) begin
            count <= count + `TCP_BYTE_ONE;
        end
    end
endmodule // tcp_prescaler
`default_nettype wire

// [logic/tcp_timer.sv]
// Eight-bit timer/counter with a prescaler shared with the watchdog.
//
// Strobed register access and the register offsets were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "tcp_regs.svh"
module tcp_timer (
    // Clock and reset.
    input wire logic clk,
    input wire logic sys_rst,
    // Register port.
    input wire tcp_pkg::tcp_byte_t regAddr,
    input wire tcp_pkg::tcp_byte_t regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output tcp_pkg::tcp_byte_t regRdData,
    // Pins.
    input wire logic externalCountInput,
    input wire logic watchdogOscillator,
    input wire logic watchdogEnableConfig,
    // Watchdog result.
    output logic watchdogTimeout
);
    import tcp_pkg::*;

    tcp_option_t optionReg;
    tcp_byte_t timerCount;
    tcp_byte_t wdCount;
    tcp_hold_t holdState;

    logic extSync1;
    logic extSync2;
    logic extPrev;
    logic wdSync1;
    logic wdSync2;
    logic wdPrev;
    logic enSync1;
    logic enSync2;

    logic clockSourceSelect;
    logic countEdgeSelect;
    logic prescalerAssign;
    logic extRise;
    logic extFall;
    logic extEdge;
    logic wdOscTick;
    logic srcEvent;
    logic timerStep;
    logic wdStep;
    logic writeCount;
    logic writeOption;
    logic wdClear;

    tcp_presc_if presc ();

    tcp_prescaler u_prescaler (
        .clk(clk),
        .sys_rst(sys_rst),
        .presc(presc)
    );

    assign clockSourceSelect = optionReg[`TCP_OPT_CS];
    assign countEdgeSelect = optionReg[`TCP_OPT_SE];
    assign prescalerAssign = optionReg[`TCP_OPT_PSA];

    assign writeCount = regWr && (regAddr == `TCP_ADDR_COUNT);
    assign writeOption = regWr && (regAddr == `TCP_ADDR_OPTION);
    assign wdClear = regWr && (regAddr == `TCP_ADDR_WDCLR);

    // Pins come from outside the clock domain and pass two flops first.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            extSync1 <= 1'b0;
            extSync2 <= 1'b0;
            extPrev <= 1'b0;
        end else begin
            extSync1 <= externalCountInput;
            extSync2 <= extSync1;
            extPrev <= extSync2;
        end
    end

    // The watchdog oscillator is sampled as a pin on the main clock, so the watchdog runs
    // at its own rate only while the main clock keeps running.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wdSync1 <= 1'b0;
            wdSync2 <= 1'b0;
            wdPrev <= 1'b0;
        end else begin
            wdSync1 <= watchdogOscillator;
            wdSync2 <= wdSync1;
            wdPrev <= wdSync2;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            enSync1 <= 1'b0;
            enSync2 <= 1'b0;
        end else begin
            enSync1 <= watchdogEnableConfig;
            enSync2 <= enSync1;
        end
    end

    assign extRise = extSync2 && !extPrev;
    assign extFall = !extSync2 && extPrev;
    // Only one edge type counts; both would double the rate.
    assign extEdge = countEdgeSelect ? extFall : extRise;
    assign wdOscTick = wdSync2 && !wdPrev;

    // Timer mode counts cycles, counter mode counts pin edges.
    assign srcEvent = clockSourceSelect ? extEdge : 1'b1;

    // The one prescaler sits in exactly one path.
    assign presc.srcTick = prescalerAssign ? wdOscTick : srcEvent;
    assign presc.rate = optionReg[`TCP_OPT_RATE_HI:`TCP_OPT_RATE_LO];
    assign presc.clear = (writeCount && !prescalerAssign) || (wdClear && prescalerAssign)
                         || writeOption;
    assign timerStep = prescalerAssign ? srcEvent : presc.divTick;
    assign wdStep = prescalerAssign ? presc.divTick : wdOscTick;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            optionReg <= `TCP_OPT_RESET;
        end else if (writeOption) begin
            optionReg <= regWrData[`TCP_OPT_CS:`TCP_OPT_RATE_LO];
        end
    end

    // A write restarts the hold-off, so back-to-back writes keep holding.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            holdState <= TCP_RUN;
        end else if (writeCount) begin
            holdState <= TCP_HOLD_A;
        end else begin
            unique case (holdState)
                TCP_RUN: holdState <= TCP_RUN;
                TCP_HOLD_A: holdState <= TCP_HOLD_B;
                TCP_HOLD_B: holdState <= TCP_RUN;
                default: holdState <= TCP_RUN;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            timerCount <= `TCP_COUNT_RESET;
        end else if (writeCount) begin
            timerCount <= regWrData;
        end else if (holdState == TCP_RUN && timerStep) begin
            // Plain eight-bit add, so FF rolls over to 00 and keeps going.
            timerCount <= timerCount + `TCP_BYTE_ONE;
        end
    end

    // No register bit turns the watchdog off; only the configuration pin does.
    always_ff @(posedge clk) begin
        if (sys_rst || wdClear || !enSync2) begin
            wdCount <= `TCP_WD_RESET;
        end else if (wdStep) begin
            wdCount <= wdCount + `TCP_BYTE_ONE;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            watchdogTimeout <= 1'b0;
        end else begin
            watchdogTimeout <= enSync2 && !wdClear && wdStep && (wdCount == `TCP_BYTE_ONES);
        end
    end

    // Read data stand only in the cycle after the strobe; the prescaler count
    // has no address at all.
    always_ff @(posedge clk) begin
        if (sys_rst || !regRd) begin
            regRdData <= `TCP_BYTE_ZERO;
        end else begin
            unique case (regAddr)
                `TCP_ADDR_COUNT: regRdData <= timerCount;
                `TCP_ADDR_OPTION: regRdData <= {2'b00, optionReg};
                `TCP_ADDR_STATUS: regRdData <= {5'h00, prescalerAssign, enSync2,
                                                holdState != TCP_RUN};
                default: regRdData <= `TCP_BYTE_ZERO;
            endcase
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    sequence s_count_write;
        writeCount;
    endsequence

    sequence s_two_quiet;
        (!writeCount) [*2];
    endsequence

    property p_write_loads;
        s_count_write |=> timerCount == $past(regWrData);
    endproperty
    a_write_loads: assert property (p_write_loads)
        else $error("count write not loaded");

    property p_read_back;
        regRd && regAddr == `TCP_ADDR_COUNT |=> regRdData == $past(timerCount);
    endproperty
    a_read_back: assert property (p_read_back)
        else $error("count read wrong");

    property p_holdoff;
        s_count_write ##1 s_two_quiet |=> timerCount == $past(timerCount, 2);
    endproperty
    a_holdoff: assert property (p_holdoff)
        else $error("count moved during hold-off");

    property p_timer_step;
        !clockSourceSelect && prescalerAssign && holdState == TCP_RUN && !writeCount
            |=> timerCount == $past(timerCount) + `TCP_BYTE_ONE;
    endproperty
    a_timer_step: assert property (p_timer_step)
        else $error("timer mode missed a cycle");

    property p_rise_count;
        clockSourceSelect && !countEdgeSelect && prescalerAssign && holdState == TCP_RUN
            && !writeCount && $rose(extSync2) |=> timerCount == $past(timerCount) + `TCP_BYTE_ONE;
    endproperty
    a_rise_count: assert property (p_rise_count)
        else $error("rising edge not counted");

    property p_fall_ignored;
        clockSourceSelect && !countEdgeSelect && !writeCount && $fell(extSync2)
            |=> timerCount == $past(timerCount);
    endproperty
    a_fall_ignored: assert property (p_fall_ignored)
        else $error("falling edge counted in rising mode");

    property p_fall_count;
        clockSourceSelect && countEdgeSelect && prescalerAssign && holdState == TCP_RUN
            && !writeCount && $fell(extSync2) |=> timerCount == $past(timerCount) + `TCP_BYTE_ONE;
    endproperty
    a_fall_count: assert property (p_fall_count)
        else $error("falling edge not counted");

    property p_div_two;
        !prescalerAssign && !clockSourceSelect && presc.rate == 3'h0 && !regWr && presc.divTick
            ##1 !regWr |-> !presc.divTick ##1 (presc.divTick || regWr);
    endproperty
    a_div_two: assert property (p_div_two)
        else $error("divide by two wrong");

    // With the prescaler on the timer, the watchdog must see the raw oscillator ticks.
    property p_wdog_route;
        !prescalerAssign |-> wdStep == wdOscTick && timerStep == presc.divTick;
    endproperty
    a_wdog_route: assert property (p_wdog_route)
        else $error("watchdog took prescaler while timer owns it");

    property p_wdog_off;
        !enSync2 |=> wdCount == `TCP_WD_RESET && !watchdogTimeout;
    endproperty
    a_wdog_off: assert property (p_wdog_off)
        else $error("watchdog ran while disabled");

    property p_unmapped;
        regRd && regAddr != `TCP_ADDR_COUNT && regAddr != `TCP_ADDR_OPTION
            && regAddr != `TCP_ADDR_STATUS |=> regRdData == `TCP_BYTE_ZERO;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");
endmodule // tcp_timer
`default_nettype wire
